// File: pia_defs.svh
// constants of the priority interrupt arbiter: register indices, fields, resets
// assumes inclusion by the package and the testbench only
`ifndef PIA_DEFS_SVH
`define PIA_DEFS_SVH
// ****************************************************************
// sizes
// ****************************************************************
`define PIA_SRC_N        46
`define PIA_FIXED_N      6
`define PIA_FIELDS_PER   8
`define PIA_VEC_W        6
`define PIA_BASE_W       15
`define PIA_HIGH_W       5
`define PIA_ADDR_W       21
`define PIA_REG_W        16
`define PIA_IDX_W        5
// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define PIA_IDX_PRIO0    5'h00
`define PIA_IDX_PRIO4    5'h04
`define PIA_IDX_VBASE    5'h05
`define PIA_IDX_FMATCH0  5'h06
`define PIA_IDX_FLOW0    5'h07
`define PIA_IDX_FHIGH0   5'h08
`define PIA_IDX_FMATCH1  5'h09
`define PIA_IDX_FLOW1    5'h0a
`define PIA_IDX_FHIGH1   5'h0b
`define PIA_IDX_PEND0    5'h0c
`define PIA_IDX_PEND1    5'h0d
`define PIA_IDX_PEND2    5'h0e
`define PIA_IDX_CTRL     5'h12
`define PIA_IDX_EVSTAT   5'h13
`define PIA_IDX_EVMASK   5'h14
// ****************************************************************
// fields and reset values
// ****************************************************************
`define PIA_FIXED_LEVEL  2'h3
`define PIA_FAST_LEVEL   2'h2
`define PIA_PRIO_OFF     2'h0
`define PIA_RST_REG      16'h0000
`define PIA_EV_W         2
`define PIA_EV_WAKE      0
`define PIA_EV_FAST      1
`endif

// File: pia_pkg.sv
// types shared by the priority interrupt arbiter and its bench
// assumes pia_defs.svh is on the include path
package pia_pkg;
  `include "pia_defs.svh"

  // bus slave states, gray order
  typedef enum logic [0:0]
  {
    PIA_BUS_IDLE = 1'b0,
    PIA_BUS_DONE = 1'b1
  } pia_bus_e;

  // answer to the core: request, kind, level, number, jump address
  typedef struct packed
  {
    logic                     irq;
    logic                     fast;
    logic [1:0]               level;
    logic [`PIA_VEC_W-1:0]    vecnum;
    logic [`PIA_ADDR_W-1:0]   addr;
  } pia_vec_s;
endpackage : pia_pkg

// File: pia_arbiter.sv
// priority interrupt arbiter: levels, per-level encoding, fast channels, wake
// assumes requests, core mask, ack and low-power come from logic on CLOCK_I
// Operation
// - 46 request inputs over four levels, software giving each programmable one level 0-2 or off
// - some sources sit at a fixed level that software cannot change
// - within a level the lowest active source number wins
// - signal the core when a permitted request exists, with its address
// - normal address is vector base joined with the vector number
// - core mask 00 all, 01 masks 0, 10 masks 0-1, 11 only 3
// - two independent fast channels, each with match and address registers
// - the winning vector number is compared against both match registers
// - fast only when number matches and the request is at level 2
// - fast interrupts use the channel address, not the base offset
// - the arbiter flags fast itself before the core decides
// - registers are reached as a slave on the peripheral bus
// - in wait or stop a pending request tells system integration to wake
// - after reset the initial program address is driven to the core
// - priority fields reset to 00 disabled, nonzero codes rising levels
// - only requests enabled before low power may wake the core
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module pia_arbiter
  import pia_pkg::*;
#(
  parameter int SRC_N   = `PIA_SRC_N,
  parameter int FIXED_N = `PIA_FIXED_N
)
(
  // clock and reset
  input  wire logic                    CLOCK_I,
  input  wire logic                    RST_I,
  // avalon-mm slave
  input  wire logic [`PIA_IDX_W-1:0]   AVS_ADDRESS_I,
  input  wire logic                    AVS_READ_I,
  input  wire logic                    AVS_WRITE_I,
  input  wire logic [31:0]             AVS_WRITEDATA_I,
  input  wire logic [3:0]              AVS_BYTEENABLE_I,
  output logic      [31:0]             AVS_READDATA_O,
  output logic                         AVS_WAITREQUEST_O,
  // requests and core
  input  wire logic [SRC_N-1:0]        IRQ_REQ_I,
  input  wire logic [1:0]              CORE_MASK_I,
  input  wire logic                    CORE_ACK_I,
  output pia_pkg::pia_vec_s            CORE_VEC_O,
  output logic                         CORE_BOOT_O,
  // system integration and software interrupt
  input  wire logic                    LOW_POWER_I,
  output logic                         WAKE_O,
  output logic                         INT_O
);
  import pia_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [`PIA_REG_W-1:0] pia_merge(input logic [`PIA_REG_W-1:0] old,
                                                      input logic [31:0] wd,
                                                      input logic [3:0]  be);
    logic [`PIA_REG_W-1:0] r;
    r = old;
    if (be[0])
      r[7:0] = wd[7:0];
    if (be[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction : pia_merge

  // six-bit vector number
  // lowest set bit wins; scanning downward leaves the smallest index last
  function automatic logic [`PIA_VEC_W-1:0] pia_first(input logic [SRC_N-1:0] v);
    logic [`PIA_VEC_W-1:0] r;
    r = '0;
    for (int i = SRC_N - 1; i >= 0; i--)
      if (v[i])
        r = `PIA_VEC_W'(i);
    return r;
  endfunction : pia_first

  // ****************************************************************
  // state
  // ****************************************************************
  logic [`PIA_REG_W-1:0]   prio_r [5];
  logic [`PIA_BASE_W-1:0]  vbase_r;
  logic [`PIA_VEC_W-1:0]   fmatch_r [2];
  logic [`PIA_REG_W-1:0]   flow_r [2];
  logic [`PIA_HIGH_W-1:0]  fhigh_r [2];
  logic [`PIA_EV_W-1:0]    evst_r;
  logic [`PIA_EV_W-1:0]    evmask_r;
  logic [`PIA_EV_W-1:0]    evst_nxt;
  logic [SRC_N-1:0]        en_snap_r;
  logic                    lp_q_r;
  logic                    boot_r;
  logic                    wake_r;
  pia_vec_s                vec_r;
  pia_vec_s                vec_nxt;
  pia_bus_e                bus_r;
  logic [31:0]             rdata_r;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  wire                     req      = AVS_READ_I | AVS_WRITE_I;
  wire                     done     = (bus_r == PIA_BUS_DONE);
  wire                     wr_take  = AVS_WRITE_I & done;
  wire [`PIA_IDX_W-1:0]    idx      = AVS_ADDRESS_I;
  wire                     is_prio  = (idx <= `PIA_IDX_PRIO4);
  wire [2:0]               prio_sel = idx[2:0];

  // one wait cycle: data is prepared while waitrequest is high
  assign AVS_WAITREQUEST_O = req & ~done;
  assign AVS_READDATA_O    = rdata_r;

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      bus_r <= PIA_BUS_IDLE;
    else if (done)
      bus_r <= PIA_BUS_IDLE;
    else if (req)
      bus_r <= PIA_BUS_DONE;
  end

  // ****************************************************************
  // source enables and levels
  // ****************************************************************
  wire                     src_en  [SRC_N];
  wire [1:0]               src_lvl [SRC_N];
  wire [SRC_N-1:0]         en_vec;
  wire [SRC_N-1:0]         act [4];

  genvar gs;
  genvar gl;
  generate
    for (gs = 0; gs < SRC_N; gs++)
    begin : g_src
      if (gs < FIXED_N)
      begin : g_fix
        assign src_en[gs]  = 1'b1;
        assign src_lvl[gs] = `PIA_FIXED_LEVEL;
      end
      else
      begin : g_prog
        localparam int R = (gs - FIXED_N) / `PIA_FIELDS_PER;
        localparam int F = 2 * ((gs - FIXED_N) % `PIA_FIELDS_PER);
        wire [1:0] code = prio_r[R][F +: 2];
        // 00 disables, 01..11 give levels 0..2
        assign src_en[gs]  = (code != `PIA_PRIO_OFF);
        assign src_lvl[gs] = code - 2'h1;
      end
      assign en_vec[gs] = src_en[gs];
      for (gl = 0; gl < 4; gl++)
      begin : g_lvl
        // each request joins only its assigned level
        assign act[gl][gs] = IRQ_REQ_I[gs] & src_en[gs] & (src_lvl[gs] == 2'(gl));
      end
    end
  endgenerate

  // ****************************************************************
  // arbitration
  // ****************************************************************
  wire [`PIA_VEC_W-1:0]    num [4];
  wire [3:0]               ok;

  generate
    for (gl = 0; gl < 4; gl++)
    begin : g_enc
      assign num[gl] = pia_first(act[gl]);
      // level permitted when not below the core mask
      assign ok[gl]  = (|act[gl]) & (2'(gl) >= CORE_MASK_I);
    end
  endgenerate

  wire                     have    = |ok;
  wire [1:0]               win_lvl = ok[3] ? 2'h3 : ok[2] ? 2'h2 : ok[1] ? 2'h1 : 2'h0;
  wire [`PIA_VEC_W-1:0]    win_num = num[win_lvl];
  wire [SRC_N-1:0]         act_win = act[win_lvl];
  wire [SRC_N-1:0]         below   = act_win & ((SRC_N'(1) << win_num) - SRC_N'(1));

  wire                     lvl_fast = (win_lvl == `PIA_FAST_LEVEL);
  wire                     hit0     = (win_num == fmatch_r[0]) & lvl_fast;
  wire                     hit1     = (win_num == fmatch_r[1]) & lvl_fast;
  // fast needs both a match and level 2
  wire                     fast_c   = have & (hit0 | hit1);

  wire [`PIA_ADDR_W-1:0]   norm_addr = {vbase_r, win_num};
  wire [`PIA_ADDR_W-1:0]   f0_addr   = {fhigh_r[0], flow_r[0]};
  wire [`PIA_ADDR_W-1:0]   f1_addr   = {fhigh_r[1], flow_r[1]};
  wire [`PIA_ADDR_W-1:0]   boot_addr = {vbase_r, `PIA_VEC_W'(0)};

  // channel 0 wins when both match
  wire [`PIA_ADDR_W-1:0]   sel_addr  = boot_r ? boot_addr :
                                       hit0   ? f0_addr   :
                                       hit1   ? f1_addr   : norm_addr;

  // request and address; fast flag travels with it
  assign vec_nxt.irq    = have & ~boot_r;
  assign vec_nxt.fast   = fast_c & ~boot_r;
  assign vec_nxt.level  = win_lvl;
  assign vec_nxt.vecnum = win_num;
  assign vec_nxt.addr   = sel_addr;

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      vec_r <= '0;
    else
      vec_r <= vec_nxt;
  end

  // boot address stands until the core takes it
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      boot_r <= 1'b1;
    else if (CORE_ACK_I)
      boot_r <= 1'b0;
  end

  assign CORE_VEC_O  = vec_r;
  assign CORE_BOOT_O = boot_r;

  // ****************************************************************
  // wake from wait or stop
  // ****************************************************************
  wire                     lp_enter = LOW_POWER_I & ~lp_q_r;
  // only sources enabled at entry may wake
  wire                     wake_nxt = LOW_POWER_I & ~lp_enter & |(IRQ_REQ_I & en_snap_r & en_vec);

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      lp_q_r    <= 1'b0;
      en_snap_r <= '0;
      wake_r    <= 1'b0;
    end
    else
    begin
      lp_q_r <= LOW_POWER_I;
      if (lp_enter)
        en_snap_r <= en_vec;
      wake_r <= wake_nxt;
    end
  end

  assign WAKE_O = wake_r;

  // ****************************************************************
  // event status, set wins over a same-cycle clear
  // ****************************************************************
  wire [`PIA_EV_W-1:0]     ev_set;
  wire [`PIA_EV_W-1:0]     ev_clr = (wr_take & (idx == `PIA_IDX_EVSTAT) & AVS_BYTEENABLE_I[0]) ?
                                    AVS_WRITEDATA_I[`PIA_EV_W-1:0] : '0;

  assign ev_set[`PIA_EV_WAKE] = wake_nxt & ~wake_r;
  assign ev_set[`PIA_EV_FAST] = CORE_ACK_I & vec_r.fast;
  assign evst_nxt             = (evst_r & ~ev_clr) | ev_set;
  assign INT_O                = |(evst_r & evmask_r);

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      for (int i = 0; i < 5; i++)
        prio_r[i] <= `PIA_RST_REG;
      vbase_r  <= '0;
      fmatch_r <= '{default: '0};
      flow_r   <= '{default: '0};
      fhigh_r  <= '{default: '0};
      evst_r   <= '0;
      evmask_r <= '0;
    end
    else
    begin
      evst_r <= evst_nxt;
      if (wr_take)
      begin
        if (is_prio)
          prio_r[prio_sel] <= pia_merge(prio_r[prio_sel], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        else if (idx == `PIA_IDX_VBASE)
          vbase_r <= `PIA_BASE_W'(pia_merge({1'b0, vbase_r}, AVS_WRITEDATA_I,
                                            AVS_BYTEENABLE_I));
        else if (idx == `PIA_IDX_FMATCH0)
          fmatch_r[0] <= `PIA_VEC_W'(pia_merge({10'h000, fmatch_r[0]}, AVS_WRITEDATA_I,
                                               AVS_BYTEENABLE_I));
        else if (idx == `PIA_IDX_FLOW0)
          flow_r[0] <= pia_merge(flow_r[0], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        else if (idx == `PIA_IDX_FHIGH0)
          fhigh_r[0] <= `PIA_HIGH_W'(pia_merge({11'h000, fhigh_r[0]}, AVS_WRITEDATA_I,
                                               AVS_BYTEENABLE_I));
        else if (idx == `PIA_IDX_FMATCH1)
          fmatch_r[1] <= `PIA_VEC_W'(pia_merge({10'h000, fmatch_r[1]}, AVS_WRITEDATA_I,
                                               AVS_BYTEENABLE_I));
        else if (idx == `PIA_IDX_FLOW1)
          flow_r[1] <= pia_merge(flow_r[1], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        else if (idx == `PIA_IDX_FHIGH1)
          fhigh_r[1] <= `PIA_HIGH_W'(pia_merge({11'h000, fhigh_r[1]}, AVS_WRITEDATA_I,
                                               AVS_BYTEENABLE_I));
        else if (idx == `PIA_IDX_EVMASK && AVS_BYTEENABLE_I[0])
          evmask_r <= AVS_WRITEDATA_I[`PIA_EV_W-1:0];
      end
    end
  end

  // ****************************************************************
  // read selection
  // ****************************************************************
  wire [47:0]              pend   = {{(48 - SRC_N){1'b0}}, IRQ_REQ_I & en_vec};
  wire [`PIA_REG_W-1:0]    ctrl_v = {10'h000, boot_r, LOW_POWER_I, vec_r.fast, vec_r.irq,
                                     CORE_MASK_I};
  wire [`PIA_REG_W-1:0]    rd_sel =
    is_prio                   ? prio_r[prio_sel]                 :
    idx == `PIA_IDX_VBASE     ? {1'b0, vbase_r}                  :
    idx == `PIA_IDX_FMATCH0   ? {10'h000, fmatch_r[0]}           :
    idx == `PIA_IDX_FLOW0     ? flow_r[0]                        :
    idx == `PIA_IDX_FHIGH0    ? {11'h000, fhigh_r[0]}            :
    idx == `PIA_IDX_FMATCH1   ? {10'h000, fmatch_r[1]}           :
    idx == `PIA_IDX_FLOW1     ? flow_r[1]                        :
    idx == `PIA_IDX_FHIGH1    ? {11'h000, fhigh_r[1]}            :
    idx == `PIA_IDX_PEND0     ? pend[15:0]                       :
    idx == `PIA_IDX_PEND1     ? pend[31:16]                      :
    idx == `PIA_IDX_PEND2     ? pend[47:32]                      :
    idx == `PIA_IDX_CTRL      ? ctrl_v                           :
    idx == `PIA_IDX_EVSTAT    ? {14'h0000, evst_r}               :
    idx == `PIA_IDX_EVMASK    ? {14'h0000, evmask_r}             : `PIA_RST_REG;

  // unmapped reads return zero, upper half always zero
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      rdata_r <= '0;
    else if (AVS_READ_I && !done)
      rdata_r <= {16'h0000, rd_sel};
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_bus_one_wait:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      req && !done |=> !AVS_WAITREQUEST_O)
    else $error("bus answer not one cycle after request");

  a_lowest_wins:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      have |-> act_win[win_num] && below == '0)
    else $error("winner is not the lowest active source");

  a_mask_level:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      vec_r.irq |-> vec_r.level >= $past(CORE_MASK_I))
    else $error("masked level presented to the core");

  a_fast_level:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      vec_r.fast |-> vec_r.irq && vec_r.level == 2'h2)
    else $error("fast flag outside level two");

  a_fast_addr:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      have && hit0 && !boot_r |=> vec_r.fast && vec_r.addr == $past(f0_addr))
    else $error("fast channel address not used");

  a_norm_addr:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      have && !fast_c && !boot_r |=> vec_r.addr == {$past(vbase_r), $past(win_num)})
    else $error("normal vector address wrong");

  a_irq_follows:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      vec_r.irq == $past(have && !boot_r))
    else $error("core request does not follow arbitration");

  a_wake_lp:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      WAKE_O |-> $past(LOW_POWER_I, 1) && $past(LOW_POWER_I, 2))
    else $error("wake outside low power");

  a_boot_hold:
    assert property (@(posedge CLOCK_I) disable iff (RST_I)
      boot_r && !CORE_ACK_I |=> boot_r && !vec_r.irq)
    else $error("boot address dropped before core ack");

endmodule : pia_arbiter

// File: pia_core_model.sv
// behavioural model of the core's exception and fetch logic facing the arbiter
// assumes the arbiter's vector output and boot flag on the same clock
`timescale 1ns/1ps
module pia_core_model
  import pia_pkg::*;
#(
  // arbitrary opcode value standing for the subroutine jump
  parameter logic [15:0] JUMP_OP = 16'h0f0f
)
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // arbiter side
  input  pia_pkg::pia_vec_s       vec_i,
  input  wire logic               boot_i,
  output logic                    ack_o,
  output logic [1:0]              mask_o,
  // bench control
  input  wire logic               en_i,
  input  wire logic [3:0]         delay_i,
  input  wire logic [1:0]         mask_want_i,
  input  wire logic [15:0]        opcode_i,
  output logic                    fast_entry_o
);
  import pia_pkg::*;
  logic [3:0] wait_r;

  assign mask_o = mask_want_i;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_o        <= 1'b0;
      wait_r       <= 4'h0;
      fast_entry_o <= 1'b0;
    end
    else
    begin
      ack_o        <= 1'b0;
      fast_entry_o <= 1'b0;
      // a slow core waits delay_i cycles before taking the vector
      if (en_i && !ack_o && (boot_i || vec_i.irq))
      begin
        if (wait_r == delay_i)
        begin
          ack_o        <= 1'b1;
          wait_r       <= 4'h0;
          fast_entry_o <= vec_i.fast && (opcode_i != JUMP_OP);
        end
        else
          wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : pia_core_model

// File: pia_testbench.sv
// self-checking bench of the priority interrupt arbiter with a core model
// assumes pia_pkg, pia_arbiter and pia_core_model are compiled before it
`timescale 1ns/1ps
`include "pia_defs.svh"
`define PIA_CMP(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  import pia_pkg::*;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk; int sel;} pia_note_s;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, lp = 1'b0, core_en = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [45:0] req = 46'h0;
  logic [1:0]  mask_want = 2'h0, mask, c;
  logic [3:0]  core_dly = 4'h0;
  logic [15:0] opc = 16'h0000, fl0, fl1;
  logic [14:0] vb;
  logic [4:0]  fh0, fh1;
  logic        wreq, boot, wake, intr, ack;
  pia_vec_s    vec;
  pia_note_s   notes[$];
  logic [1:0]  prio[46];
  int          miscompares = 0, comparisons = 0, s, seed;
  event        probe_ev;
  localparam logic [31:0] FULL = 32'h7fffffff;

  always #2 clk = ~clk;

  pia_arbiter dut (.CLOCK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'h3),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .IRQ_REQ_I(req), .CORE_MASK_I(mask),
    .CORE_ACK_I(ack), .CORE_VEC_O(vec), .CORE_BOOT_O(boot), .LOW_POWER_I(lp),
    .WAKE_O(wake), .INT_O(intr));
  pia_core_model core (.clk_i(clk), .rst_i(rst), .vec_i(vec), .boot_i(boot), .ack_o(ack),
    .mask_o(mask), .en_i(core_en), .delay_i(core_dly), .mask_want_i(mask_want),
    .opcode_i(opc), .fast_entry_o());

  // ********************
  // checking
  // ********************
  task complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task take(input logic [31:0] g);
    pia_note_s n_e;
    n_e = notes.pop_front();
    `PIA_CMP(n_e.nm, n_e.exp & n_e.msk, g & n_e.msk)
  endtask : take

  // read data is taken at the rising edge that sees waitrequest low
  always @(posedge clk)
    if (rd === 1'b1 && wreq === 1'b0)
      take(rdat);

  always
  begin
    @(probe_ev);
    @(negedge clk);
    case (notes[0].sel)
      1: take({1'b0, vec});
      2: take({31'h0, intr});
      default: take({31'h0, wake});
    endcase
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ********************
  // drivers
  // ********************
  function automatic logic [31:0] vx(input logic f, input logic [1:0] l,
                                     input logic [5:0] n, input logic [20:0] a);
    return {1'b0, 1'b1, f, l, n, a};
  endfunction : vx

  task probe(input string nm, input logic [31:0] e, input logic [31:0] m, input int sl);
    @(posedge clk);
    notes.push_back('{nm, e, m, sl});
    -> probe_ev;
    @(negedge clk);
  endtask : probe

  // waitrequest is read at the rising edge, before that edge's updates land
  task bus(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [15:0] e);
    int n;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {16'h0000, d};
    if (!w)
      notes.push_back('{"readdata", {16'h0000, e}, 32'hffffffff, 0});
    n = 0;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 64)
    begin
      miscompares++;
      complete_run();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task set_prio(input int sr, input logic [1:0] cd);
    logic [15:0] w;
    int r;
    prio[sr] = cd;
    r = (sr - 6) / 8;
    for (int k = 0; k < 8; k++)
      w[2*k+:2] = prio[6+8*r+k];
    bus(1'b1, 5'(r), w, 16'h0000);
  endtask : set_prio

  task set_req(input logic [45:0] v);
    @(posedge clk);
    req <= v;
  endtask : set_req

  task core_take(input logic [3:0] d);
    int n;
    @(posedge clk);
    core_dly <= d;
    core_en <= 1'b1;
    n = 0;
    @(negedge clk);
    while (ack !== 1'b1 && n < 32)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 32)
    begin
      miscompares++;
      complete_run();
    end
    @(posedge clk);
    core_en <= 1'b0;
  endtask : core_take

  // ********************
  // scenarios
  // ********************
  initial
  begin
    seed = $urandom(32'h5dbc4c66);
    foreach (prio[i]) prio[i] = 2'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    opc <= 16'($urandom);
    for (int i = 0; i < 12; i++)
      bus(1'b0, 5'(i), 16'h0, 16'h0000);
    bus(1'b0, `PIA_IDX_EVMASK, 16'h0, 16'h0000);
    bus(1'b1, 5'h1f, 16'hffff, 16'h0);
    bus(1'b0, 5'h1f, 16'h0, 16'h0000);
    bus(1'b0, `PIA_IDX_CTRL, 16'h0, 16'h0020);
    vb = 15'($urandom);
    bus(1'b1, `PIA_IDX_VBASE, {1'b0, vb}, 16'h0);
    probe("boot", {10'h0, vb, 6'h00}, 32'h401fffff, 1);
    core_take(4'h0);
    bus(1'b0, `PIA_IDX_CTRL, 16'h0, 16'h0000);
    set_prio(6, 2'h1);
    set_prio(7, 2'h3);
    set_req(46'h0c0);
    probe("levels", vx(1'b0, 2'h2, 6'd7, {vb, 6'd7}), FULL, 1);
    set_req(46'h0c1);
    probe("fixed", vx(1'b0, 2'h3, 6'd0, {vb, 6'd0}), FULL, 1);
    for (int t = 0; t < 4; t++)
    begin
      s = (t == 3) ? 44 : 8 + $urandom_range(35);
      c = 2'($urandom_range(3, 1));
      set_prio(s, c);
      set_prio(s + 1, c);
      set_req(46'h3 << s);
      probe("winner", vx(1'b0, 2'(c - 2'h1), 6'(s), {vb, 6'(s)}), FULL, 1);
      set_req(46'h1 << (s + 1));
      probe("loser", vx(1'b0, 2'(c - 2'h1), 6'(s + 1), {vb, 6'(s + 1)}), FULL, 1);
      set_prio(s, 2'h0);
      set_prio(s + 1, 2'h0);
    end
    set_req(46'h1 << 10);
    for (int l = 0; l < 3; l++)
    begin
      set_prio(10, 2'(l + 1));
      for (int m = 0; m < 4; m++)
      begin
        @(posedge clk);
        mask_want <= 2'(m);
        probe("mask", {1'b0, (l >= m), 30'h0}, 32'h40000000, 1);
      end
    end
    set_req(46'h2);
    probe("top", vx(1'b0, 2'h3, 6'd1, {vb, 6'd1}), FULL, 1);
    @(posedge clk);
    mask_want <= 2'h0;
    fl0 = 16'($urandom);
    fh0 = 5'($urandom);
    fl1 = ~fl0;
    fh1 = ~fh0;
    set_prio(20, 2'h3);
    bus(1'b1, `PIA_IDX_FMATCH0, 16'd20, 16'h0);
    bus(1'b1, `PIA_IDX_FLOW0, fl0, 16'h0);
    bus(1'b1, `PIA_IDX_FHIGH0, {11'h0, fh0}, 16'h0);
    set_req(46'h1 << 20);
    probe("fast0", vx(1'b1, 2'h2, 6'd20, {fh0, fl0}), FULL, 1);
    bus(1'b1, `PIA_IDX_FMATCH1, 16'd20, 16'h0);
    bus(1'b1, `PIA_IDX_FLOW1, fl1, 16'h0);
    bus(1'b1, `PIA_IDX_FHIGH1, {11'h0, fh1}, 16'h0);
    probe("both", vx(1'b1, 2'h2, 6'd20, {fh0, fl0}), FULL, 1);
    bus(1'b1, `PIA_IDX_FMATCH0, 16'd21, 16'h0);
    probe("fast1", vx(1'b1, 2'h2, 6'd20, {fh1, fl1}), FULL, 1);
    set_prio(20, 2'h2);
    probe("notlvl2", vx(1'b0, 2'h1, 6'd20, {vb, 6'd20}), FULL, 1);
    set_prio(20, 2'h3);
    core_take(4'h3);
    bus(1'b0, `PIA_IDX_EVSTAT, 16'h0, 16'h0002);
    probe("int masked", 32'h0, 32'h1, 2);
    bus(1'b1, `PIA_IDX_EVMASK, 16'h0003, 16'h0);
    probe("int on", 32'h1, 32'h1, 2);
    bus(1'b1, `PIA_IDX_EVSTAT, 16'h0002, 16'h0);
    probe("int clear", 32'h0, 32'h1, 2);
    set_req(46'h0);
    set_prio(30, 2'h1);
    @(posedge clk);
    lp <= 1'b1;
    set_req(46'h1 << 30);
    probe("wake", 32'h1, 32'h1, 3);
    bus(1'b0, `PIA_IDX_EVSTAT, 16'h0, 16'h0001);
    lp <= 1'b0;
    set_req(46'h0);
    @(posedge clk);
    lp <= 1'b1;
    set_prio(31, 2'h1);
    set_req(46'h1 << 31);
    probe("late enable", 32'h0, 32'h1, 3);
    complete_run();
  end
endmodule : testbench
